// ### io_cmd_pkg.sv
// Shared constants and types for the safe-value command handler.
// Assumes a byte-wide character stream from a UART outside this block.
package io_cmd_pkg;

    // ****************************************************************
    // Characters
    // ****************************************************************
    localparam logic [7:0] CH_TILDE = 8'h7E;
    localparam logic [7:0] CH_BANG  = 8'h21;
    localparam logic [7:0] CH_QUERY = 8'h3F;
    localparam logic [7:0] CH_CR    = 8'h0D;
    localparam logic [7:0] CH_4     = 8'h34;
    localparam logic [7:0] CH_5     = 8'h35;
    localparam logic [7:0] CH_D     = 8'h44;

    // ****************************************************************
    // Limits, layout and reset values
    // ****************************************************************
    localparam int         MAX_CMD_LEN    = 8;
    localparam int         AO_CHANNELS    = 2;
    localparam int         MAX_DATA_LEN   = 8;
    localparam int         POL_IN_BIT     = 0;
    localparam int         POL_OUT_BIT    = 1;
    localparam logic [7:0] POL_USED_MASK  = 8'h03;
    localparam logic [7:0] POL_RESET      = 8'h00;
    localparam logic [7:0] MASK_RESET     = 8'h00;

    // Character with valid flag
    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } char_t;

    // Analog output data string, left aligned, with its length
    typedef struct packed {
        logic [MAX_DATA_LEN*8-1:0] text;
        logic [3:0]                len;
    } ao_text_t;

endpackage

// ### hex_char.sv
// ASCII hex helpers: parse one character, format one nibble.
// Assumes plain combinational use on the same clock as the caller.
`timescale 1ns/1ns
module hex_char (
    input  wire logic [7:0] char_in,
    input  wire logic [3:0] nib_in,
    output logic            is_hex,
    output logic [3:0]      nib_out,
    output logic [7:0]      char_out
);
    import io_cmd_pkg::*;

    // Parse upper or lower case hex digit
    always_comb begin
        is_hex  = 1'b1;
        nib_out = 4'h0;
        if (char_in >= 8'h30 && char_in <= 8'h39) begin
            nib_out = char_in[3:0];
        end else if ((char_in >= 8'h41 && char_in <= 8'h46) ||
                     (char_in >= 8'h61 && char_in <= 8'h66)) begin
            nib_out = char_in[3:0] + 4'h9;
        end else begin
            is_hex = 1'b0;
        end
    end

    // Format nibble as upper case hex
    always_comb begin
        if (nib_in < 4'hA) begin
            char_out = {4'h3, nib_in};
        end else begin
            char_out = 8'h37 + {4'h0, nib_in};
        end
    end
endmodule

// ### io_safe_value_command_handler.sv
// Command interpreter for safe values, output defaults and polarity.
// Assumes a UART byte stream in and out, checksum already checked.
`timescale 1ns/1ns
module io_safe_value_command_handler #(
    parameter int DO_CHANNELS = 8,
    parameter int DI_CHANNELS = 8
) (
    input  wire logic                               ref_clk,
    input  wire logic                               reset_n,
    input  wire logic [7:0]                         module_address,
    input  wire io_cmd_pkg::char_t                  rx_char,
    input  wire logic                               rx_error,
    input  wire logic                               tx_ready,
    output io_cmd_pkg::char_t                       tx_char,
    input  wire io_cmd_pkg::ao_text_t [1:0]         ao_present,
    output io_cmd_pkg::ao_text_t [1:0]              ao_safe,
    input  wire logic [DO_CHANNELS-1:0]             alarm_assign,
    output logic [DO_CHANNELS-1:0]                  poweron_mask,
    output logic [DO_CHANNELS-1:0]                  safe_mask,
    output logic [7:0]                              misc_settings,
    input  wire logic [DI_CHANNELS-1:0]             di_pins,
    output logic [DI_CHANNELS-1:0]                  di_logical,
    input  wire logic [DO_CHANNELS-1:0]             do_logical,
    output logic [DO_CHANNELS-1:0]                  do_drive
);
    import io_cmd_pkg::*;

    // ****************************************************************
    // Receive buffer
    // ****************************************************************
    typedef enum {RX_IDLE, RX_BODY, RX_DROP} rx_state_t;
    typedef enum {TX_IDLE, TX_SEND} tx_state_t;

    rx_state_t        rx_state;
    tx_state_t        tx_state;
    logic [7:0]       buf_mem [MAX_CMD_LEN];
    logic [3:0]       buf_len;
    logic             frame_done;
    logic [7:0]       reply_mem [MAX_DATA_LEN+4];
    logic [3:0]       reply_len;
    logic [3:0]       reply_idx;
    logic [DI_CHANNELS-1:0] di_meta;
    logic [DI_CHANNELS-1:0] di_sync;

    // Hex parse of buffered characters, format of nibbles
    logic [3:0] nib [MAX_CMD_LEN];
    logic       hexok [MAX_CMD_LEN];
    logic [3:0] fmt_in [4];
    logic [7:0] fmt_out [4];

    genvar g;
    generate
        for (g = 0; g < MAX_CMD_LEN; g++) begin : g_parse
            hex_char u_parse (
                .char_in  (buf_mem[g]),
                .nib_in   (g < 4 ? fmt_in[g % 4] : 4'h0),
                .is_hex   (hexok[g]),
                .nib_out  (nib[g]),
                .char_out ()
            );
        end
        for (g = 0; g < 4; g++) begin : g_fmt
            hex_char u_fmt (
                .char_in  (8'h00),
                .nib_in   (fmt_in[g]),
                .is_hex   (),
                .nib_out  (),
                .char_out (fmt_out[g])
            );
        end
    endgenerate

    // Collect bytes between tilde and CR; errors and overflow drop frame
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rx_state   <= RX_IDLE;
            buf_len    <= 4'h0;
            frame_done <= 1'b0;
        end else begin
            frame_done <= 1'b0;
            if (rx_char.valid) begin
                if (rx_char.data == CH_TILDE) begin
                    rx_state <= RX_BODY;
                    buf_len  <= 4'h0;
                end else if (rx_error) begin
                    rx_state <= RX_DROP;
                end else if (rx_state == RX_BODY) begin
                    if (rx_char.data == CH_CR) begin
                        frame_done <= 1'b1;
                        rx_state   <= RX_IDLE;
                    end else if (buf_len == 4'(MAX_CMD_LEN)) begin
                        rx_state <= RX_DROP;
                    end else begin
                        buf_mem[buf_len[2:0]] <= rx_char.data;
                        buf_len <= buf_len + 4'h1;
                    end
                end else begin
                    rx_state <= RX_IDLE;
                end
            end
        end
    end

    // ****************************************************************
    // Decode
    // ****************************************************************
    logic       addr_ok;
    logic       syntax_ok;
    logic       success;
    logic [7:0] vv_reg;
    logic       ch_legal;
    logic       ch_idx;
    logic       do_store;
    logic       do_masks;
    logic       do_pol_wr;

    // Classify a completed frame
    always_comb begin
        addr_ok   = hexok[0] && hexok[1] && {nib[0], nib[1]} == module_address;
        syntax_ok = 1'b0;
        success   = 1'b0;
        do_store  = 1'b0;
        do_masks  = 1'b0;
        do_pol_wr = 1'b0;
        ch_legal  = hexok[3] && nib[3] < 4'(AO_CHANNELS);
        ch_idx    = nib[3][0];
        vv_reg    = {nib[3], nib[4]};
        fmt_in[0] = 4'h0;
        fmt_in[1] = 4'h0;
        fmt_in[2] = 4'h0;
        fmt_in[3] = 4'h0;
        case (buf_len)
            4'h3: begin
                syntax_ok = buf_mem[2] == CH_4 || buf_mem[2] == CH_D;
                success   = syntax_ok;
                fmt_in[0] = buf_mem[2] == CH_4 ? poweron_mask[7:4] : misc_settings[7:4];
                fmt_in[1] = buf_mem[2] == CH_4 ? poweron_mask[3:0] : misc_settings[3:0];
                fmt_in[2] = safe_mask[7:4];
                fmt_in[3] = safe_mask[3:0];
            end
            4'h4: begin
                syntax_ok = (buf_mem[2] == CH_4 || buf_mem[2] == CH_5) && hexok[3];
                success   = syntax_ok && ch_legal;
                do_store  = success && buf_mem[2] == CH_5;
            end
            4'h5: begin
                syntax_ok = buf_mem[2] == CH_D && hexok[3] && hexok[4];
                success   = syntax_ok;
                do_pol_wr = success;
            end
            4'h7: begin
                syntax_ok = buf_mem[2] == CH_5 && hexok[3] && hexok[4] &&
                            hexok[5] && hexok[6];
                success   = syntax_ok;
                do_masks  = success;
            end
            default: begin
                syntax_ok = 1'b0;
            end
        endcase
    end

    // ****************************************************************
    // Stored settings
    // ****************************************************************
    // Analog safe values snapshot the present output text
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            ao_safe <= '0;
        end else if (frame_done && addr_ok && do_store) begin
            ao_safe[ch_idx] <= ao_present[ch_idx];
        end
    end

    // Output masks; alarm channels keep their old bits
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            poweron_mask <= DO_CHANNELS'(MASK_RESET);
            safe_mask    <= DO_CHANNELS'(MASK_RESET);
        end else if (frame_done && addr_ok && do_masks) begin
            poweron_mask <= (poweron_mask & alarm_assign) |
                            (DO_CHANNELS'({nib[3], nib[4]}) & ~alarm_assign);
            safe_mask    <= (safe_mask & alarm_assign) |
                            (DO_CHANNELS'({nib[5], nib[6]}) & ~alarm_assign);
        end
    end

    // Polarity setting, reserved bits forced to zero
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            misc_settings <= POL_RESET;
        end else if (frame_done && addr_ok && do_pol_wr) begin
            misc_settings <= vv_reg & POL_USED_MASK;
        end
    end

    // Pin input synchroniser
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            di_meta <= '0;
            di_sync <= '0;
        end else begin
            di_meta <= di_pins;
            di_sync <= di_meta;
        end
    end

    // Apply input and output sense
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            di_logical <= '0;
            do_drive   <= '0;
        end else begin
            di_logical <= di_sync ^ {DI_CHANNELS{misc_settings[POL_IN_BIT]}};
            do_drive   <= do_logical ^ {DO_CHANNELS{misc_settings[POL_OUT_BIT]}};
        end
    end

    // ****************************************************************
    // Reply
    // ****************************************************************
    // Build reply on frame end, then stream it out
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            tx_state  <= TX_IDLE;
            reply_len <= 4'h0;
            reply_idx <= 4'h0;
        end else begin
            case (tx_state)
                TX_IDLE: begin
                    if (frame_done && addr_ok && syntax_ok) begin
                        reply_mem[0] <= success ? CH_BANG : CH_QUERY;
                        reply_mem[1] <= buf_mem[0];
                        reply_mem[2] <= buf_mem[1];
                        reply_idx    <= 4'h0;
                        reply_len    <= 4'h4;
                        reply_mem[3] <= CH_CR;
                        tx_state     <= TX_SEND;
                        if (success && buf_len == 4'h3) begin
                            reply_mem[3] <= fmt_out[0];
                            reply_mem[4] <= fmt_out[1];
                            if (buf_mem[2] == CH_4) begin
                                reply_mem[5] <= fmt_out[2];
                                reply_mem[6] <= fmt_out[3];
                                reply_mem[7] <= CH_CR;
                                reply_len    <= 4'h8;
                            end else begin
                                reply_mem[5] <= CH_CR;
                                reply_len    <= 4'h6;
                            end
                        end else if (success && buf_len == 4'h4 && buf_mem[2] == CH_4) begin
                            for (int i = 0; i < MAX_DATA_LEN; i++) begin
                                reply_mem[3+i] <= 4'(i) < ao_safe[ch_idx].len ?
                                    ao_safe[ch_idx].text[(MAX_DATA_LEN-1-i)*8 +: 8] :
                                    CH_CR;
                            end
                            reply_mem[MAX_DATA_LEN+3] <= CH_CR;
                            reply_len <= ao_safe[ch_idx].len + 4'h4;
                        end
                    end
                end
                TX_SEND: begin
                    if (tx_ready) begin
                        reply_idx <= reply_idx + 4'h1;
                        if (reply_idx + 4'h1 == reply_len) begin
                            tx_state <= TX_IDLE;
                        end
                    end
                end
                default: tx_state <= TX_IDLE;
            endcase
        end
    end

    // Present current reply byte
    always_comb begin
        tx_char.valid = tx_state == TX_SEND;
        tx_char.data  = tx_state == TX_SEND ? reply_mem[reply_idx] : 8'h00;
    end
endmodule

// ### io_cmd_sva.sv
// Port checker for the safe-value command handler.
// Assumes a bind onto the handler; sees only its ports.
`timescale 1ns/1ns
module io_cmd_sva #(
    parameter int DO_CHANNELS = 8,
    parameter int DI_CHANNELS = 8
) (
    input wire logic                       ref_clk,
    input wire logic                       reset_n,
    input wire logic [7:0]                 module_address,
    input wire io_cmd_pkg::char_t          rx_char,
    input wire logic                       rx_error,
    input wire logic                       tx_ready,
    input wire io_cmd_pkg::char_t          tx_char,
    input wire io_cmd_pkg::ao_text_t [1:0] ao_present,
    input wire io_cmd_pkg::ao_text_t [1:0] ao_safe,
    input wire logic [DO_CHANNELS-1:0]     alarm_assign,
    input wire logic [DO_CHANNELS-1:0]     poweron_mask,
    input wire logic [DO_CHANNELS-1:0]     safe_mask,
    input wire logic [7:0]                 misc_settings,
    input wire logic [DI_CHANNELS-1:0]     di_pins,
    input wire logic [DI_CHANNELS-1:0]     di_logical,
    input wire logic [DO_CHANNELS-1:0]     do_logical,
    input wire logic [DO_CHANNELS-1:0]     do_drive
);
    import io_cmd_pkg::*;
    logic [3:0] idx;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    // Upper-case hex digit of a nibble
    function automatic logic [7:0] hx(input logic [3:0] n);
        return (n < 4'hA) ? 8'h30 + {4'h0, n} : 8'h37 + {4'h0, n};
    endfunction

    // Position of the current byte within a reply
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) idx <= 4'h0;
        else if (!tx_char.valid) idx <= 4'h0;
        else if (tx_ready) idx <= idx + 4'h1;
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    a_reply_delim: assert property (tx_char.valid && idx == 4'h0 |->
        tx_char.data == CH_BANG || tx_char.data == CH_QUERY) else $error("bad reply start");
    a_addr_high: assert property (tx_char.valid && idx == 4'h1 |->
        tx_char.data == hx(module_address[7:4])) else $error("bad address high digit");
    a_addr_low: assert property (tx_char.valid && idx == 4'h2 |->
        tx_char.data == hx(module_address[3:0])) else $error("bad address low digit");
    a_tx_hold: assert property (tx_char.valid && !tx_ready |=>
        tx_char.valid && $stable(tx_char.data)) else $error("reply byte not held");
    a_reserved_zero: assert property (misc_settings[7:2] == 6'h00)
        else $error("reserved polarity bits set");
    a_di_sense: assert property (
        ($stable(di_pins) && $stable(misc_settings))[*4] |->
        di_logical == (di_pins ^ {DI_CHANNELS{misc_settings[POL_IN_BIT]}}))
        else $error("input sense wrong");
    a_do_sense: assert property ($past(reset_n) |-> do_drive ==
        ($past(do_logical) ^ {DO_CHANNELS{$past(misc_settings[POL_OUT_BIT])}}))
        else $error("output sense wrong");
    a_alarm_ignore: assert property ($stable(alarm_assign) |->
        (((poweron_mask ^ $past(poweron_mask)) | (safe_mask ^ $past(safe_mask))) &
        alarm_assign) == '0) else $error("alarm channel mask changed");
    a_safe_capture: assert property ($changed(ao_safe[0]) |->
        ao_safe[0] == $past(ao_present[0]) && tx_char.data == CH_BANG)
        else $error("safe value not captured");
    a_config_update: assert property ($changed(misc_settings) |->
        tx_char.valid && tx_char.data == CH_BANG) else $error("polarity changed unacked");
    a_error_silent: assert property (!tx_char.valid && rx_char.valid && rx_error |=>
        !tx_char.valid [*4]) else $error("reply after comm error");

    c_success: cover property (tx_char.valid && idx == 4'h0 && tx_char.data == CH_BANG);
    c_failure: cover property (tx_char.valid && idx == 4'h0 && tx_char.data == CH_QUERY);
    c_stall: cover property (tx_char.valid && !tx_ready);
endmodule

bind io_safe_value_command_handler io_cmd_sva #(
    .DO_CHANNELS(DO_CHANNELS), .DI_CHANNELS(DI_CHANNELS)) i_sva (
    .ref_clk(ref_clk), .reset_n(reset_n), .module_address(module_address),
    .rx_char(rx_char), .rx_error(rx_error), .tx_ready(tx_ready), .tx_char(tx_char),
    .ao_present(ao_present), .ao_safe(ao_safe), .alarm_assign(alarm_assign),
    .poweron_mask(poweron_mask), .safe_mask(safe_mask), .misc_settings(misc_settings),
    .di_pins(di_pins), .di_logical(di_logical), .do_logical(do_logical), .do_drive(do_drive));

// ### host_model.sv
// Host controller that sends framed commands and collects replies.
// Assumes the handler's byte-wide receive and transmit ports.
`timescale 1ns/1ns
module host_model (
    input  wire logic              ref_clk,
    output io_cmd_pkg::char_t      rx_char,
    output logic                   rx_error,
    output logic                   tx_ready,
    input  wire io_cmd_pkg::char_t tx_char
);
    import io_cmd_pkg::*;
    logic [7:0] got [$];
    logic       slow = 1'b0;

    initial begin
        rx_char = '0;
        rx_error = 1'b0;
        tx_ready = 1'b1;
    end

    // Takes reply bytes; slow mode stalls every other cycle
    always @(posedge ref_clk) begin
        if (tx_char.valid && tx_ready) got.push_back(tx_char.data);
        #1 tx_ready = slow ? ~tx_ready : 1'b1;
    end

    // Sends tilde, address and body, then CR; idle data line toggles
    task automatic send(input string body, input bit err);
        string f;
        f = {"~", body, "\r"};
        for (int i = 0; i < f.len(); i++) begin
            rx_char.valid = 1'b1;
            rx_char.data = f[i];
            rx_error = err && (i == f.len() - 1);
            @(posedge ref_clk);
            #1;
            rx_char.valid = 1'b0;
            rx_char.data = ~rx_char.data;
            rx_error = 1'b0;
            @(posedge ref_clk);
            #1;
        end
    endtask
endmodule

// ### testbench.sv
// Self-checking bench for the command handler.
// Assumes the host model drives the serial byte ports.
`timescale 1ns/1ns
module testbench;
    import io_cmd_pkg::*;
    logic           ref_clk = 1'b0;
    logic           reset_n = 1'b0;
    logic [7:0]     module_address = 8'hA5;
    char_t          rx_char;
    logic           rx_error;
    logic           tx_ready;
    char_t          tx_char;
    ao_text_t [1:0] ao_present;
    ao_text_t [1:0] ao_safe;
    logic [7:0]     alarm_assign = 8'h80;
    logic [7:0]     poweron_mask;
    logic [7:0]     safe_mask;
    logic [7:0]     misc_settings;
    logic [7:0]     di_pins = 8'h0F;
    logic [7:0]     di_logical;
    logic [7:0]     do_logical = 8'h3C;
    logic [7:0]     do_drive;
    int             bad_count = 0;
    int             samples_checked = 0;
    string          av [2] = '{"+06.000", "-01.250"};

    always #2 ref_clk = ~ref_clk;

    io_safe_value_command_handler i_dut (
        .ref_clk(ref_clk), .reset_n(reset_n), .module_address(module_address),
        .rx_char(rx_char), .rx_error(rx_error), .tx_ready(tx_ready), .tx_char(tx_char),
        .ao_present(ao_present), .ao_safe(ao_safe), .alarm_assign(alarm_assign),
        .poweron_mask(poweron_mask), .safe_mask(safe_mask), .misc_settings(misc_settings),
        .di_pins(di_pins), .di_logical(di_logical), .do_logical(do_logical), .do_drive(do_drive));

    host_model i_host (.ref_clk(ref_clk), .rx_char(rx_char), .rx_error(rx_error),
        .tx_ready(tx_ready), .tx_char(tx_char));

    // ****************************************************************
    // Compare and access tasks
    // ****************************************************************
    task automatic check_val(input string name, input logic [67:0] exp, input logic [67:0] got);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic check_str(input string name, input string exp, input string got);
        samples_checked++;
        if (got != exp) begin
            bad_count++;
            $display("unexpected reply to %s expected %s seen %s", name, exp, got);
        end
    endtask

    // Sends one command and waits a bounded time for its reply
    task automatic cmd(input string body, input string exp, input bit err);
        string s;
        string g;
        s = (exp == "") ? "" : {exp, "<CR>"};
        g = "";
        i_host.got.delete();
        i_host.send(body, err);
        repeat (80) begin
            @(posedge ref_clk);
            #1;
            if (i_host.got.size() > 0 && i_host.got[$] === CH_CR) break;
        end
        // Carriage returns shown as text so a mismatch line stays whole
        foreach (i_host.got[i]) begin
            if (i_host.got[i] === CH_CR) g = {g, "<CR>"};
            else g = {g, $sformatf("%c", i_host.got[i])};
        end
        check_str(body, s, g);
    endtask

    task automatic report_and_stop();
        if (bad_count == 0 && samples_checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // Watchdog against a hung reply
    initial begin
        #100000;
        bad_count++;
        report_and_stop();
    end

    // ****************************************************************
    // Test sequence
    // ****************************************************************
    initial begin
        ao_present[0] = {{"+06.000", 8'h00}, 4'h7};
        ao_present[1] = {{"-01.250", 8'h00}, 4'h7};
        repeat (2) @(posedge ref_clk);
        #1;
        reset_n = 1'b1;
        cmd("A5D", "!A500", 0);
        for (int k = 0; k < 2; k++) begin
            // New pin pattern each pass; replies give the synchroniser time to settle
            di_pins = k ? 8'h5A : 8'h0F;
            cmd(k ? "A5D00" : "A5DFF", "!A5", 0);
            check_val("misc_settings", k ? 8'h00 : 8'h03, misc_settings);
            cmd("A5D", k ? "!A500" : "!A503", 0);
            check_val("di_logical", k ? 8'h5A : 8'hF0, di_logical);
            check_val("do_drive", k ? 8'h3C : 8'hC3, do_drive);
        end
        cmd("A54", "!A50000", 0);
        cmd("A550102", "!A5", 0);
        check_val("poweron_mask", 8'h01, poweron_mask);
        check_val("safe_mask", 8'h02, safe_mask);
        cmd("A54", "!A50102", 0);
        cmd("A55FFFF", "!A5", 0);
        check_val("poweron_mask", 8'h7F, poweron_mask);
        check_val("safe_mask", 8'h7F, safe_mask);
        check_val("ao_safe", 68'h0, ao_safe[0]);
        i_host.slow = 1'b1;
        for (int ch = 0; ch < 2; ch++) begin
            cmd($sformatf("A55%0d", ch), "!A5", 0);
            check_val("ao_safe", ao_present[ch], ao_safe[ch]);
            cmd($sformatf("A54%0d", ch), {"!A5", av[ch]}, 0);
        end
        i_host.slow = 1'b0;
        cmd("A552", "?A5", 0);
        cmd("A54F", "?A5", 0);
        cmd("A6D", "", 0);
        cmd("A5X", "", 0);
        cmd("A5D", "", 1);
        module_address = 8'hFF;
        cmd("FFD", "!FF00", 0);
        report_and_stop();
    end
endmodule
